/* File: asm_pkg.sv */
// constants and types shared by the alert source masking block
package asm_pkg;

  // ----------------------------------------------------------------
  // command and status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
  localparam logic [7:0] CODE_OUT_VOLT = 8'h7A;
  localparam logic [7:0] CODE_OUT_CURR = 8'h7B;
  localparam logic [7:0] CODE_INPUT = 8'h7C;
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  localparam logic [7:0] BLOCK_LEN_ONE = 8'h01;

  // ----------------------------------------------------------------
  // transaction kinds presented by the link engine
  // ----------------------------------------------------------------
  localparam logic KIND_WRITE_WORD = 1'b0;
  localparam logic KIND_PROC_CALL = 1'b1;

  // ----------------------------------------------------------------
  // writable bits of each mask; the rest read as zero
  // ----------------------------------------------------------------
  localparam logic [7:0] WMASK_OUT_VOLT = 8'hFC;
  localparam logic [7:0] WMASK_OUT_CURR = 8'hB0;
  localparam logic [7:0] WMASK_INPUT = 8'h08;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_MASK_OUT_OVERVOLT_FAULT = 7;
  localparam int POS_MASK_OUT_OVERVOLT_WARN = 6;
  localparam int POS_MASK_OUT_UNDERVOLT_WARN = 5;
  localparam int POS_MASK_OUT_UNDERVOLT_FAULT = 4;
  localparam int POS_MASK_OUT_LIMIT_RANGE = 3;
  localparam int POS_MASK_TURN_ON_TIMEOUT = 2;
  localparam int POS_MASK_OVERCURRENT_FAULT = 7;
  localparam int POS_MASK_OVERCURRENT_WARN = 5;
  localparam int POS_MASK_UNDERCURRENT_FAULT = 4;
  localparam int POS_MASK_INPUT_LOW = 3;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [0:0] {
    ST_LOAD,
    ST_RUN
  } asm_state_t;

endpackage : asm_pkg

/* File: asm_sync.sv */
// two-flop synchroniser for level signals entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module asm_sync
  import asm_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_in, // destination clock
  input wire logic rst_n_in, // asynchronous reset, active low
  input wire logic [WIDTH-1:0] d_in, // level from the other domain
  output logic [WIDTH-1:0] q_out // synchronised level
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } asm_sync_state_t;

  asm_sync_state_t cur_reg;
  asm_sync_state_t cur_next;

  // the first stage is read only by the second
  always_comb
  begin
    cur_next = cur_reg;
    cur_next.stage1 = d_in;
    cur_next.stage2 = cur_reg.stage1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cur_reg <= '0;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  assign q_out = cur_reg.stage2;

endmodule : asm_sync
`default_nettype wire

/* File: asm_alert_mask.sv */
// alert mask registers, command decode and alert line gating
`timescale 1ns/1ps
`default_nettype none
module asm_alert_mask
  import asm_pkg::*;
(
  input wire logic REF_CLK_IN, // core clock, 200 MHz
  input wire logic RESET_N_IN, // asynchronous reset, active low
  input wire logic LINK_CLK_IN, // link engine clock
  input wire logic LINK_FRAME_VALID_IN, // one-cycle pulse, frame complete
  input wire logic LINK_KIND_IN, // write word or process call
  input wire logic [7:0] LINK_CMD_IN, // command code of the frame
  input wire logic [7:0] LINK_COUNT_IN, // block byte count (process call)
  input wire logic [7:0] LINK_LOW_IN, // low data byte or block byte
  input wire logic [7:0] LINK_HIGH_IN, // high data byte (write word)
  input wire logic [7:0] PHASE_IN, // current phase selection
  input wire logic [7:0] STATUS_OUT_VOLT_IN, // output-voltage status bits
  input wire logic [7:0] STATUS_OUT_CURR_IN, // output-current status bits
  input wire logic [7:0] STATUS_INPUT_IN, // input status bits
  input wire logic [7:0] NVM_OUT_VOLT_IN, // stored output-voltage mask
  input wire logic [7:0] NVM_OUT_CURR_IN, // stored output-current mask
  input wire logic [7:0] NVM_INPUT_IN, // stored input mask
  output logic LINK_BUSY_OUT, // frame held, new frames dropped
  output logic LINK_DONE_OUT, // one-cycle pulse, frame finished
  output logic [7:0] LINK_REPLY_COUNT_OUT, // reply block count
  output logic [7:0] LINK_REPLY_DATA_OUT, // reply block byte
  output logic LINK_REPLY_ERR_OUT, // frame was refused
  output logic ALERT_N_OUT, // shared alert line, active low
  output logic CMD_ERR_OUT, // one-cycle pulse, command refused
  output logic DATA_ERR_OUT, // one-cycle pulse, bad data
  output logic [7:0] MASK_OUT_VOLT_OUT, // output-voltage mask
  output logic [7:0] MASK_OUT_CURR_OUT, // output-current mask
  output logic [7:0] MASK_INPUT_OUT // input mask
);

  // ----------------------------------------------------------------
  // state of each domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic req_toggle;
    logic ack_seen;
    logic kind;
    logic [7:0] cmd;
    logic [7:0] count;
    logic [7:0] low;
    logic [7:0] high;
    logic done;
    logic [7:0] reply_count;
    logic [7:0] reply_data;
    logic reply_err;
  } asm_link_state_t;

  typedef struct packed {
    asm_state_t state;
    logic req_seen;
    logic ack_toggle;
    logic [7:0] mask_out_volt;
    logic [7:0] mask_out_curr;
    logic [7:0] mask_input;
    logic [7:0] reply_data;
    logic reply_err;
    logic alert_n;
    logic cmd_err;
    logic data_err;
  } asm_core_state_t;

  asm_link_state_t link_reg;
  asm_link_state_t link_next;
  asm_core_state_t core_reg;
  asm_core_state_t core_next;

  logic req_sync;
  logic ack_sync;

  // ----------------------------------------------------------------
  // domain crossings
  // ----------------------------------------------------------------
  // the held frame fields and the reply bytes stay still while their
  // toggle is in flight, so only the toggles need synchronising

  asm_sync #(
    .WIDTH(1)
  ) u_req_sync (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .d_in(link_reg.req_toggle),
    .q_out(req_sync)
  );

  asm_sync #(
    .WIDTH(1)
  ) u_ack_sync (
    .clk_in(LINK_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .d_in(core_reg.ack_toggle),
    .q_out(ack_sync)
  );

  // ----------------------------------------------------------------
  // link side: capture a frame, hand it over, return the answer
  // ----------------------------------------------------------------
  // limitation: the link engine must keep its clock running (stretch)
  // until the done pulse, since the answer is taken on this clock
  always_comb
  begin
    link_next = link_reg;
    link_next.done = 1'b0;
    if (!link_reg.busy)
    begin
      if (LINK_FRAME_VALID_IN)
      begin
        link_next.busy = 1'b1;
        link_next.kind = LINK_KIND_IN;
        link_next.cmd = LINK_CMD_IN;
        link_next.count = LINK_COUNT_IN;
        link_next.low = LINK_LOW_IN;
        link_next.high = LINK_HIGH_IN;
        link_next.req_toggle = ~link_reg.req_toggle;
      end
    end
    else if (ack_sync != link_reg.ack_seen)
    begin
      link_next.ack_seen = ack_sync;
      link_next.busy = 1'b0;
      link_next.done = 1'b1;
      link_next.reply_err = core_reg.reply_err;
      if (link_reg.kind == KIND_PROC_CALL)
      begin
        link_next.reply_count = BLOCK_LEN_ONE;
        link_next.reply_data = core_reg.reply_data;
      end
      else
      begin
        link_next.reply_count = RST_BYTE;
        link_next.reply_data = RST_BYTE;
      end
    end
  end

  always_ff @(posedge LINK_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      link_reg <= '0;
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  // ----------------------------------------------------------------
  // core side: mask storage, decode and alert gating
  // ----------------------------------------------------------------
  logic phase_ok;
  logic cmd_ok;
  logic code_ok;
  logic [7:0] sel_mask;
  logic [7:0] sel_wmask;
  logic [7:0] new_mask;
  logic [7:0] code;
  logic [7:0] raised;

  always_comb
  begin
    phase_ok = (PHASE_IN == PHASE_ALL);
    cmd_ok = (link_reg.cmd == CMD_ALERT_MASK);
    code = link_reg.low;
    code_ok = 1'b1;
    sel_mask = RST_MASK;
    sel_wmask = RST_MASK;
    case (code)
      CODE_OUT_VOLT:
      begin
        sel_mask = core_reg.mask_out_volt;
        sel_wmask = WMASK_OUT_VOLT;
      end
      CODE_OUT_CURR:
      begin
        sel_mask = core_reg.mask_out_curr;
        sel_wmask = WMASK_OUT_CURR;
      end
      CODE_INPUT:
      begin
        sel_mask = core_reg.mask_input;
        sel_wmask = WMASK_INPUT;
      end
      default:
      begin
        code_ok = 1'b0;
      end
    endcase
    // unimplemented bits drop here and so read back as zero
    new_mask = link_reg.high & sel_wmask;
  end

  // ----------------------------------------------------------------
  // gate bits, one per named condition
  // ----------------------------------------------------------------
  // built bit by bit so only implemented conditions can ever be masked;
  // a status bit in an unimplemented position always raises the alert
  logic [7:0] gate_volt;
  logic [7:0] gate_curr;
  logic [7:0] gate_input;

  always_comb
  begin
    gate_volt = RST_MASK;
    gate_curr = RST_MASK;
    gate_input = RST_MASK;
    gate_volt[POS_MASK_OUT_OVERVOLT_FAULT] =
      core_reg.mask_out_volt[POS_MASK_OUT_OVERVOLT_FAULT];
    gate_volt[POS_MASK_OUT_OVERVOLT_WARN] =
      core_reg.mask_out_volt[POS_MASK_OUT_OVERVOLT_WARN];
    gate_volt[POS_MASK_OUT_UNDERVOLT_WARN] =
      core_reg.mask_out_volt[POS_MASK_OUT_UNDERVOLT_WARN];
    gate_volt[POS_MASK_OUT_UNDERVOLT_FAULT] =
      core_reg.mask_out_volt[POS_MASK_OUT_UNDERVOLT_FAULT];
    gate_volt[POS_MASK_OUT_LIMIT_RANGE] =
      core_reg.mask_out_volt[POS_MASK_OUT_LIMIT_RANGE];
    gate_volt[POS_MASK_TURN_ON_TIMEOUT] =
      core_reg.mask_out_volt[POS_MASK_TURN_ON_TIMEOUT];
    gate_curr[POS_MASK_OVERCURRENT_FAULT] =
      core_reg.mask_out_curr[POS_MASK_OVERCURRENT_FAULT];
    gate_curr[POS_MASK_OVERCURRENT_WARN] =
      core_reg.mask_out_curr[POS_MASK_OVERCURRENT_WARN];
    gate_curr[POS_MASK_UNDERCURRENT_FAULT] =
      core_reg.mask_out_curr[POS_MASK_UNDERCURRENT_FAULT];
    gate_input[POS_MASK_INPUT_LOW] =
      core_reg.mask_input[POS_MASK_INPUT_LOW];
  end

  always_comb
  begin
    core_next = core_reg;
    core_next.cmd_err = 1'b0;
    core_next.data_err = 1'b0;
    case (core_reg.state)
      ST_LOAD:
      begin
        // store values are caught one clock after reset release
        core_next.mask_out_volt = NVM_OUT_VOLT_IN & WMASK_OUT_VOLT;
        core_next.mask_out_curr = NVM_OUT_CURR_IN & WMASK_OUT_CURR;
        core_next.mask_input = NVM_INPUT_IN & WMASK_INPUT;
        core_next.state = ST_RUN;
      end
      ST_RUN:
      begin
        if (req_sync != core_reg.req_seen)
        begin
          core_next.req_seen = req_sync;
          core_next.ack_toggle = ~core_reg.ack_toggle;
          core_next.reply_data = RST_BYTE;
          core_next.reply_err = 1'b1;
          if (!cmd_ok || !phase_ok)
          begin
            core_next.cmd_err = 1'b1;
          end
          else if (link_reg.kind == KIND_WRITE_WORD)
          begin
            if (code_ok)
            begin
              core_next.reply_err = 1'b0;
              if (code == CODE_OUT_VOLT)
              begin
                core_next.mask_out_volt = new_mask;
              end
              if (code == CODE_OUT_CURR)
              begin
                core_next.mask_out_curr = new_mask;
              end
              if (code == CODE_INPUT)
              begin
                core_next.mask_input = new_mask;
              end
            end
            else
            begin
              core_next.data_err = 1'b1;
            end
          end
          else if (code_ok && link_reg.count == BLOCK_LEN_ONE)
          begin
            core_next.reply_err = 1'b0;
            core_next.reply_data = sel_mask;
          end
          else
          begin
            core_next.data_err = 1'b1;
          end
        end
      end
      default:
      begin
        core_next.state = ST_LOAD;
      end
    endcase
    // gating uses the current masks, so a written mask acts on the
    // very next alert update without touching regulation
    raised = (STATUS_OUT_VOLT_IN & ~gate_volt)
           | (STATUS_OUT_CURR_IN & ~gate_curr)
           | (STATUS_INPUT_IN & ~gate_input);
    // status bits are only read here, never cleared or changed
    core_next.alert_n = ~(|raised);
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      core_reg.state <= ST_LOAD;
      core_reg.req_seen <= 1'b0;
      core_reg.ack_toggle <= 1'b0;
      core_reg.mask_out_volt <= RST_MASK;
      core_reg.mask_out_curr <= RST_MASK;
      core_reg.mask_input <= RST_MASK;
      core_reg.reply_data <= RST_BYTE;
      core_reg.reply_err <= 1'b0;
      core_reg.alert_n <= 1'b1;
      core_reg.cmd_err <= 1'b0;
      core_reg.data_err <= 1'b0;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign LINK_BUSY_OUT = link_reg.busy;
  assign LINK_DONE_OUT = link_reg.done;
  assign LINK_REPLY_COUNT_OUT = link_reg.reply_count;
  assign LINK_REPLY_DATA_OUT = link_reg.reply_data;
  assign LINK_REPLY_ERR_OUT = link_reg.reply_err;
  assign ALERT_N_OUT = core_reg.alert_n;
  assign CMD_ERR_OUT = core_reg.cmd_err;
  assign DATA_ERR_OUT = core_reg.data_err;
  assign MASK_OUT_VOLT_OUT = core_reg.mask_out_volt;
  assign MASK_OUT_CURR_OUT = core_reg.mask_out_curr;
  assign MASK_INPUT_OUT = core_reg.mask_input;

endmodule : asm_alert_mask
`default_nettype wire

/* File: asm_alert_mask_checker.sv */
// assertions on the ports of the alert source masking block
`timescale 1ns/1ps
`default_nettype none
module asm_alert_mask_checker
  import asm_pkg::*;
(
  input wire logic REF_CLK_IN, // core clock
  input wire logic RESET_N_IN, // reset, active low
  input wire logic LINK_CLK_IN, // link clock
  input wire logic LINK_FRAME_VALID_IN, // frame pulse
  input wire logic LINK_BUSY_OUT, // frame held
  input wire logic LINK_DONE_OUT, // frame finished
  input wire logic [7:0] LINK_REPLY_DATA_OUT, // reply byte
  input wire logic LINK_REPLY_ERR_OUT, // frame refused
  input wire logic ALERT_N_OUT, // alert line
  input wire logic [7:0] STATUS_OUT_VOLT_IN, // status
  input wire logic [7:0] STATUS_OUT_CURR_IN, // status
  input wire logic [7:0] STATUS_INPUT_IN, // status
  input wire logic [7:0] MASK_OUT_VOLT_OUT, // mask
  input wire logic [7:0] MASK_OUT_CURR_OUT, // mask
  input wire logic [7:0] MASK_INPUT_OUT // mask
);
  wire logic hit = |(STATUS_OUT_VOLT_IN & ~MASK_OUT_VOLT_OUT)
    | |(STATUS_OUT_CURR_IN & ~MASK_OUT_CURR_OUT)
    | |(STATUS_INPUT_IN & ~MASK_INPUT_OUT);
  // the load edge is skipped: alert settles one edge later
  property p_alert;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    $past(RESET_N_IN, 2) |-> ALERT_N_OUT == !$past(hit);
  endproperty
  a_alert: assert property (p_alert) else $error("alert gating wrong");
  property p_ro;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (MASK_OUT_VOLT_OUT & ~WMASK_OUT_VOLT) == 8'h00
      && (MASK_OUT_CURR_OUT & ~WMASK_OUT_CURR) == 8'h00
      && (MASK_INPUT_OUT & ~WMASK_INPUT) == 8'h00;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only mask bit set");
  property p_done1;
    @(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    LINK_DONE_OUT |=> !LINK_DONE_OUT;
  endproperty
  a_done1: assert property (p_done1) else $error("done too long");
  property p_busy;
    @(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    LINK_FRAME_VALID_IN && !LINK_BUSY_OUT |=> LINK_BUSY_OUT;
  endproperty
  a_busy: assert property (p_busy) else $error("frame not taken");
  property p_lat;
    @(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    $rose(LINK_BUSY_OUT) |-> LINK_BUSY_OUT[*2] ##[0:6] LINK_DONE_OUT;
  endproperty
  a_lat: assert property (p_lat) else $error("done late or early");
  property p_fall;
    @(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    $fell(LINK_BUSY_OUT) |-> LINK_DONE_OUT;
  endproperty
  a_fall: assert property (p_fall) else $error("busy fell alone");
  property p_hold;
    @(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    !LINK_DONE_OUT |-> $stable(LINK_REPLY_DATA_OUT) && $stable(LINK_REPLY_ERR_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("reply moved");
  property p_errz;
    @(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    LINK_DONE_OUT && LINK_REPLY_ERR_OUT |-> LINK_REPLY_DATA_OUT == 8'h00;
  endproperty
  a_errz: assert property (p_errz) else $error("refused reply data");
endmodule : asm_alert_mask_checker
bind asm_alert_mask asm_alert_mask_checker u_chk (.REF_CLK_IN, .RESET_N_IN,
  .LINK_CLK_IN, .LINK_FRAME_VALID_IN, .LINK_BUSY_OUT, .LINK_DONE_OUT,
  .LINK_REPLY_DATA_OUT, .LINK_REPLY_ERR_OUT, .ALERT_N_OUT,
  .STATUS_OUT_VOLT_IN, .STATUS_OUT_CURR_IN, .STATUS_INPUT_IN,
  .MASK_OUT_VOLT_OUT, .MASK_OUT_CURR_OUT, .MASK_INPUT_OUT);
`default_nettype wire

/* File: asm_link_host.sv */
// link-side host model: link clock and decoded frames
`timescale 1ns/1ps
`default_nettype none
module asm_link_host
  import asm_pkg::*;
(
  input wire logic run_in, // keep clock running
  input wire logic busy_in, // frame held
  output logic clk_out, // link clock, 12 ns
  output logic valid_out, // frame pulse
  output logic kind_out, // frame kind
  output logic [7:0] cmd_out, // command
  output logic [7:0] cnt_out, // block count
  output logic [7:0] low_out, // low byte
  output logic [7:0] high_out // high byte
);
  logic on;
  initial
  begin
    on = 1'b0;
    clk_out = 1'b0;
    valid_out = 1'b0;
    kind_out = 1'b0;
    {cmd_out, cnt_out, low_out, high_out} = 32'h0;
    #1.3;
    // clock stands low between frames
    forever
      #6 clk_out = (on || run_in) ? ~clk_out : 1'b0;
  end
  task automatic frame(input logic k, input logic [7:0] c, n, l, h,
    input bit dup);
    on = 1'b1;
    @(posedge clk_out);
    valid_out <= 1'b1;
    kind_out <= k;
    {cmd_out, cnt_out, low_out, high_out} <= {c, n, l, h};
    @(posedge clk_out);
    if (dup)
    begin
      high_out <= ~h;
      @(posedge clk_out);
    end
    valid_out <= 1'b0;
    // released fields flip so a stale value never looks valid
    {cmd_out, cnt_out, low_out, high_out} <= ~{c, n, l, h};
    do
      @(posedge clk_out);
    while (busy_in === 1'b1);
    repeat (2) @(posedge clk_out);
    on = 1'b0;
  endtask : frame
endmodule : asm_link_host
`default_nettype wire

/* File: asm_alert_mask_tb.sv */
// self-checking testbench for the alert source masking block
`timescale 1ns/1ps
`default_nettype none
module asm_alert_mask_tb
  import asm_pkg::*;
;
  localparam logic [7:0] CODES [3] = '{CODE_OUT_VOLT, CODE_OUT_CURR, CODE_INPUT};
  localparam logic [7:0] WM [3] = '{WMASK_OUT_VOLT, WMASK_OUT_CURR, WMASK_INPUT};
  logic ref_clk, rst_n, run, lclk, valid, kind, busy, done, rerr, alert_n, ok;
  logic cmd_err, data_err;
  int cmd_cnt, data_cnt;
  logic [7:0] cmd, cnt, low, high, phase, rcnt, rdata, v;
  logic [7:0] st [3];
  logic [7:0] nvm [3];
  logic [7:0] mk [3];
  logic [7:0] mo [3];
  logic [16:0] exp_q [$];
  logic [16:0] e;
  int error_cnt, compares, cyc, i, j;
  asm_alert_mask uut (.REF_CLK_IN(ref_clk), .RESET_N_IN(rst_n),
    .LINK_CLK_IN(lclk), .LINK_FRAME_VALID_IN(valid), .LINK_KIND_IN(kind),
    .LINK_CMD_IN(cmd), .LINK_COUNT_IN(cnt), .LINK_LOW_IN(low),
    .LINK_HIGH_IN(high), .PHASE_IN(phase), .STATUS_OUT_VOLT_IN(st[0]),
    .STATUS_OUT_CURR_IN(st[1]), .STATUS_INPUT_IN(st[2]),
    .NVM_OUT_VOLT_IN(nvm[0]), .NVM_OUT_CURR_IN(nvm[1]),
    .NVM_INPUT_IN(nvm[2]), .LINK_BUSY_OUT(busy), .LINK_DONE_OUT(done),
    .LINK_REPLY_COUNT_OUT(rcnt), .LINK_REPLY_DATA_OUT(rdata),
    .LINK_REPLY_ERR_OUT(rerr), .ALERT_N_OUT(alert_n),
    .CMD_ERR_OUT(cmd_err), .DATA_ERR_OUT(data_err),
    .MASK_OUT_VOLT_OUT(mo[0]), .MASK_OUT_CURR_OUT(mo[1]),
    .MASK_INPUT_OUT(mo[2]));
  asm_link_host host (.run_in(run), .busy_in(busy), .clk_out(lclk),
    .valid_out(valid), .kind_out(kind), .cmd_out(cmd), .cnt_out(cnt),
    .low_out(low), .high_out(high));
  task automatic chk(input string nm, input logic [7:0] ex, got);
    compares++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic xfer(input logic k, input logic [7:0] c, n, l, h,
    input logic [16:0] ex, input bit dup);
    exp_q.push_back(ex);
    host.frame(k, c, n, l, h, dup);
  endtask : xfer
  task results;
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  initial
  begin
    ref_clk = 1'b0;
    forever
      #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cmd_err === 1'b1)
      cmd_cnt++;
    if (data_err === 1'b1)
      data_cnt++;
    if (cyc == 40000)
    begin
      error_cnt++;
      results();
    end
  end
  // each finished frame takes the oldest expected reply
  always @(posedge lclk)
  begin
    if (done === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("reply_extra", 8'h00, 8'hFF);
      else
      begin
        e = exp_q.pop_front();
        chk("reply_err", {7'h0, e[16]}, {7'h0, rerr});
        if (!e[16])
          chk("reply_count", e[15:8], rcnt);
        chk("reply_data", e[7:0], rdata);
      end
    end
  end
  initial
  begin
    rst_n = 1'b0;
    run = 1'b1;
    phase = PHASE_ALL;
    v = $urandom(12241);
    for (i = 0; i < 3; i++)
    begin
      st[i] = 8'h00;
      nvm[i] = $urandom;
    end
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run <= 1'b0;
    for (i = 0; i < 3; i++)
    begin
      mk[i] = nvm[i] & WM[i];
      chk("mask_load", mk[i], mo[i]);
    end
    for (j = 0; j < 3; j++)
      for (i = 0; i < 3; i++)
      begin
        v = (j == 0) ? 8'hFF : (j == 1) ? 8'h00 : 8'($urandom);
        xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, 8'h01, CODES[i], v, 17'h0, 0);
        mk[i] = v & WM[i];
        chk("mask_write", mk[i], mo[i]);
        xfer(KIND_PROC_CALL, CMD_ALERT_MASK, BLOCK_LEN_ONE, CODES[i], ~v,
          {9'h001, mk[i]}, 0);
      end
    // unknown code, wrong command, bad count, wrong phase
    for (i = 0; i < 4; i++)
    begin
      phase <= (i == 3) ? 8'h00 : PHASE_ALL;
      repeat (4) @(posedge ref_clk);
      xfer(i == 2, (i == 1) ? 8'h1C : CMD_ALERT_MASK, (i == 2) ? 8'h02 : 8'h01,
        (i == 0) ? 8'h7D : CODE_OUT_VOLT, ~mk[0], 17'h10000, 0);
    end
    phase <= PHASE_ALL;
    chk("mask_kept", mk[0], mo[0]);
    chk("cmd_err", 8'h02, 8'(cmd_cnt));
    chk("data_err", 8'h02, 8'(data_cnt));
    xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, 8'h01, CODE_OUT_CURR, 8'hFF,
      17'h0, 1);
    mk[1] = WM[1];
    chk("mask_dup", mk[1], mo[1]);
    for (j = 0; j < 24; j++)
    begin
      if (j % 8 == 0)
      begin
        v = $urandom;
        xfer(KIND_WRITE_WORD, CMD_ALERT_MASK, 8'h01, CODES[j / 8], v,
          17'h0, 0);
        mk[j / 8] = v & WM[j / 8];
      end
      @(posedge ref_clk);
      for (i = 0; i < 3; i++)
        st[i] <= 8'($urandom & $urandom & $urandom);
      repeat (3) @(posedge ref_clk);
      ok = 1'b0;
      for (i = 0; i < 3; i++)
        ok = ok | (|(st[i] & ~mk[i]));
      chk("alert", {7'h0, !ok}, {7'h0, alert_n});
    end
    repeat (10) @(posedge ref_clk);
    chk("reply_left", 8'h00, 8'(exp_q.size()));
    chk("cmd_err_end", 8'h02, 8'(cmd_cnt));
    chk("data_err_end", 8'h02, 8'(data_cnt));
    results();
  end
endmodule : asm_alert_mask_tb
`default_nettype wire
